// ### logic/dcid_pkg.sv
// Package: offsets, field layouts and fixed values of the capability registers
package dcid_pkg;
    localparam logic [11:0] dcid_off_mem = 12'h008;
    localparam logic [11:0] dcid_off_per = 12'h010;
    localparam logic [11:0] dcid_off_did = 12'h004;
    localparam logic [11:0] dcid_off_gate_run = 12'h100;
    localparam logic [11:0] dcid_off_gate_slp = 12'h110;
    localparam logic [11:0] dcid_off_gate_dsl = 12'h120;
    localparam logic [31:0] dcid_sys_base = 32'h400fe000;
    localparam logic [15:0] dcid_ram_size = 16'h00ff;
    localparam logic [15:0] dcid_nvm_size = 16'h007f;
    localparam logic [2:0] dcid_temp_grade = 3'h1;
    localparam logic [1:0] dcid_pkg_type = 2'h1;
    localparam logic dcid_compliance = 1'b1;
    localparam logic [1:0] dcid_qualification_status_default = 2'h2;
    localparam logic [6:0] dcid_per_present = 7'h7f;
    localparam logic [31:0] dcid_gate_reset = 32'h00000000;
    // Clock-gating field positions, then AHB transfer and size codes
    localparam int dcid_gate_pwm_bit = 20;
    localparam int dcid_gate_adc_bit = 16;
    localparam int dcid_gate_spd_lo = 8;
    localparam int dcid_gate_wdt_bit = 3;
    localparam int dcid_gate_swo_bit = 2;
    localparam int dcid_gate_swd_bit = 1;
    localparam int dcid_gate_jtag_bit = 0;
    localparam logic [1:0] dcid_htrans_nonseq = 2'h2;
    localparam logic [2:0] dcid_hsize_word = 3'h2;

    typedef struct packed {
        logic [15:0] ram_size_field;
        logic [15:0] nvm_size_field;
    } dcid_mem_t;

    typedef struct packed {
        logic [18:0] reserved_hi;
        logic [2:0] temp_grade;
        logic [1:0] package_type;
        logic substance_compliance;
        logic [1:0] qualification_status;
        logic [4:0] reserved_mid;
    } dcid_did_unused_t;

    typedef struct packed {
        logic [10:0] haddr;
        logic hwrite;
        logic sel;
    } dcid_aphase_t;
endpackage

// ### logic/dcid_regs.sv
// Capability and identification registers behind an AHB-Lite slave
// Notes on behaviour
// - Memory capability word is read-only at offset 0x008 of the block.
// - Its upper half always reads 0x00ff, meaning 64 KB of SRAM.
// - Its lower half always reads 0x007f, meaning 256 KB of flash.
// - Peripheral capability word is read-only at offset 0x010.
// - Capability values are fixed by the part and cannot be altered.
// - PWM, converter, watchdog and debug bits mask gating; speed field always passes.
// - Gating bits other than those and the speed field read as zero.
// - A converter speed written to gating is clipped to the reported max.
// - Peripheral bits 6 to 3 read one: hibernate, thermal, PLL, watchdog.
// - Peripheral bits 2 to 0 read one: trace, serial wire and JTAG debug.
// - Identification bits 7:5 read 0x1 for the industrial range.
// - Identification bits 4:3 read 0x1 for a quad flat package.
// - Identification bit 2 reads one, the compliance flag.
// - Identification bits 1:0 give qualification status, 0, 1 or 2.
// - Reserved identification bits 12:8 read zero.
module dcid_regs #(
    parameter logic [1:0] QUALIFICATION_STATUS_STATUS = dcid_pkg::dcid_qualification_status_default,
    parameter logic [1:0] MAX_SPEED = 2'h3,
    parameter logic PWM_PRESENT = 1'b1,
    parameter logic CONV_PRESENT = 1'b1,
    // Upper identification bits: arbitrary neutral value
    parameter logic [18:0] ID_UPPER = 19'h00000
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Masked clock-gating values for the clock controller
    output logic [31:0] run_clock_gating_o,
    output logic [31:0] sleep_clock_gating_o,
    output logic [31:0] deep_sleep_clock_gating_o
);
    dcid_pkg::dcid_aphase_t aphase;
    dcid_pkg::dcid_mem_t mem_word;
    logic [31:0] per_word;
    logic [31:0] did_word;
    logic [31:0] gate_mask;
    logic [31:0] run_clock_gating;
    logic [31:0] sleep_clock_gating;
    logic [31:0] deep_sleep_clock_gating;
    logic [31:0] next_rdata;
    logic [31:0] rdata;
    logic take;

    // Mask, then clip the two-bit speed field to the reported maximum
    function automatic logic [31:0] gate_filter(input logic [31:0] w);
        logic [31:0] f;
        f = w & gate_mask;
        if (f[dcid_pkg::dcid_gate_spd_lo +: 2] > MAX_SPEED) begin
            f[dcid_pkg::dcid_gate_spd_lo +: 2] = MAX_SPEED;
        end
        return f;
    endfunction

    always_comb begin
        gate_mask = '0;
        gate_mask[dcid_pkg::dcid_gate_pwm_bit] = PWM_PRESENT;
        gate_mask[dcid_pkg::dcid_gate_adc_bit] = CONV_PRESENT;
        gate_mask[dcid_pkg::dcid_gate_spd_lo +: 2] = 2'h3;
        gate_mask[dcid_pkg::dcid_gate_wdt_bit] = per_word[3];
        gate_mask[dcid_pkg::dcid_gate_swo_bit] = per_word[2];
        gate_mask[dcid_pkg::dcid_gate_swd_bit] = per_word[1];
        gate_mask[dcid_pkg::dcid_gate_jtag_bit] = per_word[0];
    end

    // Fixed values: constants, so nothing can alter them
    assign mem_word.ram_size_field = dcid_pkg::dcid_ram_size;
    assign mem_word.nvm_size_field = dcid_pkg::dcid_nvm_size;

    always_comb begin
        per_word = '0;
        per_word[6:0] = dcid_pkg::dcid_per_present;
        per_word[20] = PWM_PRESENT;
        per_word[16] = CONV_PRESENT;
        per_word[9:8] = MAX_SPEED;
    end

    always_comb begin
        did_word = '0;
        did_word[31:13] = ID_UPPER;
        did_word[12:8] = 5'h00;
        did_word[7:5] = dcid_pkg::dcid_temp_grade;
        did_word[4:3] = dcid_pkg::dcid_pkg_type;
        did_word[2] = dcid_pkg::dcid_compliance;
        did_word[1:0] = QUALIFICATION_STATUS_STATUS;
    end

    assign take = hsel_i && hready_i
        && (htrans_i == dcid_pkg::dcid_htrans_nonseq);

    // Address phase capture
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aphase <= '0;
        end else if (hready_i) begin
            aphase.sel <= take;
            aphase.hwrite <= hwrite_i;
            aphase.haddr <= haddr_i[11:1];
        end
    end

    // Gating registers are the only writable state
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_clock_gating <= dcid_pkg::dcid_gate_reset;
            sleep_clock_gating <= dcid_pkg::dcid_gate_reset;
            deep_sleep_clock_gating <= dcid_pkg::dcid_gate_reset;
        end else if (aphase.sel && aphase.hwrite) begin
            case ({aphase.haddr, 1'b0})
                dcid_pkg::dcid_off_gate_run: begin
                    run_clock_gating <= gate_filter(hwdata_i);
                end
                dcid_pkg::dcid_off_gate_slp: begin
                    sleep_clock_gating <= gate_filter(hwdata_i);
                end
                dcid_pkg::dcid_off_gate_dsl: begin
                    deep_sleep_clock_gating <= gate_filter(hwdata_i);
                end
                default: begin
                    // Read-only and unmapped words drop the write
                    run_clock_gating <= run_clock_gating;
                end
            endcase
        end
    end

    // Read decode in the address phase so data is registered
    always_comb begin
        case ({haddr_i[11:2], 2'b00})
            dcid_pkg::dcid_off_mem: next_rdata = mem_word;
            dcid_pkg::dcid_off_per: next_rdata = per_word;
            dcid_pkg::dcid_off_did: next_rdata = did_word;
            dcid_pkg::dcid_off_gate_run: next_rdata = run_clock_gating;
            dcid_pkg::dcid_off_gate_slp: next_rdata = sleep_clock_gating;
            dcid_pkg::dcid_off_gate_dsl: next_rdata = deep_sleep_clock_gating;
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata <= 32'h00000000;
        end else if (take && !hwrite_i) begin
            rdata <= next_rdata;
        end
    end

    assign hrdata_o = rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign run_clock_gating_o = run_clock_gating;
    assign sleep_clock_gating_o = sleep_clock_gating;
    assign deep_sleep_clock_gating_o = deep_sleep_clock_gating;
endmodule

// ### dv/dcid_regs_assertions.sv
// Checker for the capability register slave
module dcid_chk #(
    parameter logic [1:0] MAX_SPEED = 2'h3
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Gating
    input wire logic [31:0] run_clock_gating_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    logic tk;
    logic rd;
    assign tk = hsel_i && hready_i && htrans_i == 2'h2;
    assign rd = tk && !hwrite_i;
    a_ready_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
    a_mem_word: assert property (rd && haddr_i[11:0] == 12'h008
        |=> hrdata_o == 32'h00ff007f) else $error("memory word wrong");
    a_per_bits: assert property (rd && haddr_i[11:0] == 12'h010
        |=> hrdata_o[6:0] == 7'h7f) else $error("peripheral bits wrong");
    a_id_fields: assert property (rd && haddr_i[11:0] == 12'h004
        |=> hrdata_o[12:2] == 11'h00b) else $error("id fields wrong");
    a_data_hold: assert property (!rd |=> $stable(hrdata_o))
        else $error("read data moved without a read");
    a_gate_zero: assert property ((run_clock_gating_o & ~32'h0011030f) == 0)
        else $error("unmasked gating bit set");
    a_speed_clip: assert property (run_clock_gating_o[9:8] <= MAX_SPEED)
        else $error("converter speed not clipped");
    a_gate_still: assert property (!$past(tk && hwrite_i, 2)
        |-> $stable(run_clock_gating_o)) else $error("gating moved");
    c_mem_read: cover property (rd && haddr_i[11:0] == 12'h008);
    c_write: cover property (tk && hwrite_i);
    c_clip: cover property (run_clock_gating_o[9:8] == MAX_SPEED);
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the capability register slave
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic wr;
        logic [11:0] off;
        logic [31:0] wd;
        logic [1:0] sel;
        logic [31:0] exp;
    } dcid_row_t;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic hreadyout_o, hresp_o;
    logic [3:0][31:0] outs;
    int fails = 0;
    int check_count = 0;
    dcid_row_t rows [6] = '{
        '{1'b0, 12'h004, 32'h0, 2'h0, 32'h0000002e},
        '{1'b0, 12'h008, 32'h0, 2'h0, 32'h00ff007f},
        '{1'b0, 12'h010, 32'h0, 2'h0, 32'h0011017f},
        '{1'b1, 12'h100, 32'hffffffff, 2'h1, 32'h0011010f},
        '{1'b1, 12'h110, 32'h00000200, 2'h2, 32'h00000100},
        '{1'b1, 12'h120, 32'h00120009, 2'h3, 32'h00100009}};
    // Speed limit 1 so that clipping shows
    dcid_regs #(.MAX_SPEED(2'h1)) dcid_regs_inst (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(dcid_pkg::dcid_hsize_word), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(outs[0]),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .run_clock_gating_o(outs[1]), .sleep_clock_gating_o(outs[2]),
        .deep_sleep_clock_gating_o(outs[3]));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] off,
            input logic [31:0] wd);
        hsel_i <= 1'b1;
        haddr_i <= dcid_pkg::dcid_sys_base | {20'h0, off};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial forever #10 clock_i = ~clock_i;
    initial begin
        #200us;
        fails++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clock_i);
        arst_n_i <= 1'b1;
        chk(outs[1], 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            xfer(rows[i].wr, rows[i].off, rows[i].wd);
            // Gating shows one cycle after the data phase
            if (rows[i].wr) @(posedge clock_i);
            chk(outs[rows[i].sel], rows[i].exp);
        end
        $display("test table done");
        xfer(1'b1, 12'h008, 32'hffffffff);
        xfer(1'b1, 12'h010, 32'h0);
        xfer(1'b0, 12'h008, 32'h0);
        chk(outs[0], 32'h00ff007f);
        xfer(1'b0, 12'h010, 32'h0);
        chk(outs[0], 32'h0011017f);
        xfer(1'b0, 12'h03c, 32'h0);
        chk(outs[0], 32'h0);
        chk(outs[1], 32'h0011010f);
        chk({31'h0, hresp_o}, 32'h0);
        $display("test read-only done");
        arst_n_i <= 1'b0;
        @(posedge clock_i);
        chk(outs[0], 32'h0);
        chk(outs[1], 32'h0);
        chk(outs[2], 32'h0);
        chk(outs[3], 32'h0);
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        xfer(1'b0, 12'h008, 32'h0);
        chk(outs[0], 32'h00ff007f);
        $display("test mid-run reset done");
        summarize();
    end
endmodule
bind dcid_regs dcid_chk #(.MAX_SPEED(MAX_SPEED)) dcid_chk_inst (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .run_clock_gating_o(run_clock_gating_o));
